// >>> fcps_pkg.sv
/*
  Shared constants and types for the flash sequencer: register offsets,
  field positions, reset values, command bytes, state codes and array
  geometry.
  Assumes a 12-bit register address, 8-bit register data and a 16-bit
  flash byte address.
*/
package fcps_pkg;

  // Register offsets
  localparam logic [11:0] FCPS_CTRL_OFS = 12'hFF8; // State read, command write
  localparam logic [11:0] FCPS_PAGE_OFS = 12'hFF9; // Page select or sector protect
  localparam logic [11:0] FCPS_CFG_OFS = 12'hFFA;  // Size select and reject flag

  // Field positions
  localparam int FCPS_INFO_BIT = 7;     // Info area enable in page select
  localparam int FCPS_CFG_SIZE_BIT = 0; // 1 selects the 8 KB array
  localparam int FCPS_CFG_REJ_BIT = 1;  // Sticky reject flag, write 1 to clear
  localparam int FCPS_PAGE_LSB = 9;     // Page number sits above a 512-byte offset
  localparam int FCPS_SECT_LSB_4K = 9;  // 512-byte sectors
  localparam int FCPS_SECT_LSB_8K = 10; // 1024-byte sectors
  localparam int FCPS_SECT_W = 3;       // Eight sectors
  localparam int FCPS_NUM_SECT = 8;

  // Reset values
  localparam logic [7:0] FCPS_PAGE_RST = 8'h00;
  localparam logic [7:0] FCPS_PROT_RST = 8'h00;
  localparam logic FCPS_SIZE_RST = 1'b0;

  // Command bytes; the values are a free choice of this block
  localparam logic [7:0] FCPS_CMD_UNLOCK1 = 8'h73;
  localparam logic [7:0] FCPS_CMD_UNLOCK2 = 8'h8C;
  localparam logic [7:0] FCPS_CMD_PAGE_ERASE = 8'h95;
  localparam logic [7:0] FCPS_CMD_MASS_ERASE = 8'h63;
  localparam logic [7:0] FCPS_CMD_SECT_PROT = 8'h5E;

  // Six-bit state codes shown in the state register
  localparam logic [5:0] FCPS_CODE_LOCKED = 6'h00;
  localparam logic [5:0] FCPS_CODE_FIRST = 6'h01;
  localparam logic [5:0] FCPS_CODE_SECOND = 6'h02;
  localparam logic [5:0] FCPS_CODE_UNLOCKED = 6'h03;
  localparam logic [5:0] FCPS_CODE_PROT = 6'h04;
  localparam logic [5:0] FCPS_CODE_PROG = 6'h08;
  localparam logic [5:0] FCPS_CODE_PAGE = 6'h10;
  localparam logic [5:0] FCPS_CODE_MASS = 6'h20;

  // Walk limits, one byte per clock
  localparam logic [12:0] FCPS_PAGE_LAST = 13'h01FF;   // 512 bytes
  localparam logic [12:0] FCPS_MASS_LAST_4K = 13'h0FFF; // 4096 bytes
  localparam logic [12:0] FCPS_MASS_LAST_8K = 13'h1FFF; // 8192 bytes
  localparam logic [7:0] FCPS_ERASED = 8'hFF;

  typedef enum logic [2:0] {
    FCPS_ST_LOCKED,
    FCPS_ST_FIRST,
    FCPS_ST_SECOND,
    FCPS_ST_UNLOCKED,
    FCPS_ST_PROT_SEL,
    FCPS_ST_PROG,
    FCPS_ST_PAGE,
    FCPS_ST_MASS
  } fcps_state_t;

endpackage

// >>> fcps_sect_guard.sv
/*
  Sector guard: tells whether a flash byte address lies outside the array
  or inside a protected sector.
  Assumes the protect mask and size select are stable register outputs.
*/
module fcps_sect_guard (
  input wire logic [15:0] addr,
  input wire logic size_8k,
  input wire logic [7:0] prot,
  output logic blocked
);

  logic [2:0] sect_idx; // Sector holding the address
  logic in_range;       // Address lies inside the fitted array
  logic [7:0] hit;      // One bit per protected sector that matches

  // Sector n starts at n times the sector size
  assign sect_idx = size_8k ? addr[fcps_pkg::FCPS_SECT_LSB_8K +: fcps_pkg::FCPS_SECT_W]
                            : addr[fcps_pkg::FCPS_SECT_LSB_4K +: fcps_pkg::FCPS_SECT_W]; // RQ3
  assign in_range = size_8k ? (addr[15:13] == 3'h0) : (addr[15:12] == 4'h0); // RQ3

  // Each sector compares its own index and its own protect bit
  genvar gi;
  generate
    for (gi = 0; gi < fcps_pkg::FCPS_NUM_SECT; gi++) begin : g_sect
      assign hit[gi] = (sect_idx == 3'(gi)) && prot[gi]; // RQ2
    end
  endgenerate

  assign blocked = (|hit) || !in_range; // RQ12

endmodule

// >>> fcps_flash_ctrl.sv
/*
  Flash sequencer: unlock sequence, sector protection, page and mass erase
  walks, byte programming from the processor or the debugger, and the
  state, page select and configuration registers.
  Assumes a single-cycle register port with read data one cycle later, and
  a flash array that writes fl_wdata to fl_addr on every clock with fl_we.
*/
// What this block does
// [RQ1] Page of 512 bytes is smallest erase
// [RQ2] Eight sectors, each separately program-erase protected
// [RQ3] 4 KB or 8 KB array, sector n at n*size
// [RQ4] Processor or debugger may program in circuit
// [RQ5] State register readable always, shares command address
// [RQ6] Upper two state bits read as zero
// [RQ7] Codes show unlock progress and protect select
// [RQ8] Running operation kind shows in state code
// [RQ9] Page erase fills selected page with FFH
// [RQ10] Page select hidden while protect access enabled
// [RQ11] Two unlock commands; wrong sequence relocks
// [RQ12] Locked or protected requests leave array untouched
module fcps_flash_ctrl (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [11:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic cpu_prog_req,
  input wire logic [15:0] cpu_prog_addr,
  input wire logic [7:0] cpu_prog_data,
  input wire logic dbg_prog_req,
  input wire logic [15:0] dbg_prog_addr,
  input wire logic [7:0] dbg_prog_data,
  output logic prog_ready,
  output logic [15:0] fl_addr,
  output logic [7:0] fl_wdata,
  output logic fl_we,
  output logic fl_info,
  output logic busy
);

  fcps_pkg::fcps_state_t st_r, st_nxt; // Sequencer state
  logic [12:0] cnt_r;     // Erase walk offset
  logic [7:0] page_r;     // Page select register
  logic [7:0] prot_r;     // Sector protect register, set-only
  logic size_r;           // 1 = 8 KB array
  logic rej_r, rej_nxt;   // Sticky reject flag
  logic [7:0] rdata_r;    // Read data, valid one cycle after the strobe
  logic [15:0] fl_addr_r; // Array address
  logic [7:0] fl_wdata_r; // Array data
  logic fl_we_r;          // Array write strobe
  logic fl_info_r;        // Info area select toward the array
  logic [5:0] code;       // Six-bit state code

  // Register port decode
  logic wr_ctrl, wr_page, wr_cfg, rd_ctrl, rd_page, rd_cfg;
  assign wr_ctrl = bus_wr && (bus_addr == fcps_pkg::FCPS_CTRL_OFS);
  assign wr_page = bus_wr && (bus_addr == fcps_pkg::FCPS_PAGE_OFS);
  assign wr_cfg = bus_wr && (bus_addr == fcps_pkg::FCPS_CFG_OFS);
  assign rd_ctrl = bus_rd && (bus_addr == fcps_pkg::FCPS_CTRL_OFS);
  assign rd_page = bus_rd && (bus_addr == fcps_pkg::FCPS_PAGE_OFS);
  assign rd_cfg = bus_rd && (bus_addr == fcps_pkg::FCPS_CFG_OFS);

  // State groups
  logic in_unl, erasing, prot_sel;
  assign in_unl = (st_r == fcps_pkg::FCPS_ST_SECOND) || (st_r == fcps_pkg::FCPS_ST_UNLOCKED);
  assign erasing = (st_r == fcps_pkg::FCPS_ST_PAGE) || (st_r == fcps_pkg::FCPS_ST_MASS);
  assign prot_sel = (st_r == fcps_pkg::FCPS_ST_PROT_SEL);
  assign busy = erasing || (st_r == fcps_pkg::FCPS_ST_PROG);

  // Program request select; the debugger wins a tie since it halts the core anyway
  logic req_any;
  logic [15:0] req_addr;
  logic [7:0] req_data;
  assign req_any = cpu_prog_req || dbg_prog_req; // RQ4
  assign req_addr = dbg_prog_req ? dbg_prog_addr : cpu_prog_addr; // RQ4
  assign req_data = dbg_prog_req ? dbg_prog_data : cpu_prog_data;

  // Erase geometry
  logic [15:0] page_base, erase_addr;
  logic [12:0] walk_last;
  logic walk_done;
  assign page_base = {page_r[6:0], 9'h000}; // RQ9
  assign walk_last = (st_r == fcps_pkg::FCPS_ST_PAGE) ? fcps_pkg::FCPS_PAGE_LAST
                   : (size_r ? fcps_pkg::FCPS_MASS_LAST_8K : fcps_pkg::FCPS_MASS_LAST_4K); // RQ1
  assign walk_done = (cnt_r == walk_last);
  assign erase_addr = ((st_r == fcps_pkg::FCPS_ST_PAGE) ? page_base : 16'h0000)
                    + {3'h0, cnt_r}; // RQ9

  // Protection checks for the page to erase and the byte to program
  logic page_blocked, req_blocked;
  fcps_sect_guard u_page_guard (
    .addr(page_base),
    .size_8k(size_r),
    .prot(prot_r),
    .blocked(page_blocked)
  );
  fcps_sect_guard u_req_guard (
    .addr(req_addr),
    .size_8k(size_r),
    .prot(prot_r),
    .blocked(req_blocked)
  );

  // Command decode; a command write in the same cycle holds off programming
  logic cmd_page, cmd_mass, page_ok, mass_ok, prog_ok, reject_evt;
  assign cmd_page = wr_ctrl && in_unl && (bus_wdata == fcps_pkg::FCPS_CMD_PAGE_ERASE);
  assign cmd_mass = wr_ctrl && in_unl && (bus_wdata == fcps_pkg::FCPS_CMD_MASS_ERASE);
  assign page_ok = cmd_page && !page_blocked; // RQ2
  assign mass_ok = cmd_mass && (prot_r == 8'h00); // RQ2
  assign prog_ready = (st_r == fcps_pkg::FCPS_ST_UNLOCKED) && !wr_ctrl; // RQ12
  assign prog_ok = req_any && prog_ready && !req_blocked; // RQ12
  assign reject_evt = (req_any && !prog_ok) || (cmd_page && page_blocked)
                    || (cmd_mass && (prot_r != 8'h00)); // RQ12

  // Next state
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      fcps_pkg::FCPS_ST_LOCKED: begin
        if (wr_ctrl && (bus_wdata == fcps_pkg::FCPS_CMD_UNLOCK1)) begin
          st_nxt = fcps_pkg::FCPS_ST_FIRST; // RQ7
        end else if (wr_ctrl && (bus_wdata == fcps_pkg::FCPS_CMD_SECT_PROT)) begin
          st_nxt = fcps_pkg::FCPS_ST_PROT_SEL; // RQ7
        end
      end
      fcps_pkg::FCPS_ST_FIRST: begin
        // Any other write between the two unlock commands breaks the sequence
        if (wr_ctrl && (bus_wdata == fcps_pkg::FCPS_CMD_UNLOCK2)) begin
          st_nxt = fcps_pkg::FCPS_ST_SECOND; // RQ11
        end else if (bus_wr) begin
          st_nxt = fcps_pkg::FCPS_ST_LOCKED; // RQ11
        end
      end
      fcps_pkg::FCPS_ST_SECOND, fcps_pkg::FCPS_ST_UNLOCKED: begin
        if (page_ok) begin
          st_nxt = fcps_pkg::FCPS_ST_PAGE;
        end else if (mass_ok) begin
          st_nxt = fcps_pkg::FCPS_ST_MASS;
        end else if (wr_ctrl) begin
          st_nxt = fcps_pkg::FCPS_ST_LOCKED; // RQ11
        end else if (prog_ok) begin
          st_nxt = fcps_pkg::FCPS_ST_PROG;
        end else begin
          st_nxt = fcps_pkg::FCPS_ST_UNLOCKED;
        end
      end
      fcps_pkg::FCPS_ST_PROT_SEL: begin
        if (wr_ctrl) begin
          st_nxt = fcps_pkg::FCPS_ST_LOCKED;
        end
      end
      fcps_pkg::FCPS_ST_PROG: begin
        st_nxt = fcps_pkg::FCPS_ST_UNLOCKED;
      end
      fcps_pkg::FCPS_ST_PAGE, fcps_pkg::FCPS_ST_MASS: begin
        // Erase relocks so a stray write cannot start a second one
        if (walk_done) begin
          st_nxt = fcps_pkg::FCPS_ST_LOCKED;
        end
      end
      default: begin
        st_nxt = fcps_pkg::FCPS_ST_LOCKED;
      end
    endcase
  end

  // State code; low bits during an operation are left at zero
  always_comb begin
    case (st_r)
      fcps_pkg::FCPS_ST_LOCKED: code = fcps_pkg::FCPS_CODE_LOCKED;
      fcps_pkg::FCPS_ST_FIRST: code = fcps_pkg::FCPS_CODE_FIRST; // RQ7
      fcps_pkg::FCPS_ST_SECOND: code = fcps_pkg::FCPS_CODE_SECOND; // RQ7
      fcps_pkg::FCPS_ST_UNLOCKED: code = fcps_pkg::FCPS_CODE_UNLOCKED;
      fcps_pkg::FCPS_ST_PROT_SEL: code = fcps_pkg::FCPS_CODE_PROT; // RQ7
      fcps_pkg::FCPS_ST_PROG: code = fcps_pkg::FCPS_CODE_PROG; // RQ8
      fcps_pkg::FCPS_ST_PAGE: code = fcps_pkg::FCPS_CODE_PAGE; // RQ8
      fcps_pkg::FCPS_ST_MASS: code = fcps_pkg::FCPS_CODE_MASS; // RQ8
      default: code = fcps_pkg::FCPS_CODE_LOCKED;
    endcase
  end

  // Read mux; the shared address shows protect bits only in protect mode
  logic [7:0] rd_mux;
  assign rd_mux = rd_ctrl ? {2'b00, code} // RQ5 RQ6
                : rd_page ? (prot_sel ? prot_r : page_r) // RQ10
                : rd_cfg ? {6'h00, rej_r, size_r}
                : 8'h00;

  // Reject flag: a new event beats a clear in the same cycle
  assign rej_nxt = reject_evt || (rej_r && !(wr_cfg && bus_wdata[fcps_pkg::FCPS_CFG_REJ_BIT]));

  // Sequencer state and walk counter
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_r <= fcps_pkg::FCPS_ST_LOCKED;
      cnt_r <= 13'h0000;
    end else begin
      st_r <= st_nxt;
      cnt_r <= (erasing && !walk_done) ? cnt_r + 13'h0001 : 13'h0000; // RQ1
    end
  end

  // Software registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      page_r <= fcps_pkg::FCPS_PAGE_RST;
      prot_r <= fcps_pkg::FCPS_PROT_RST;
      size_r <= fcps_pkg::FCPS_SIZE_RST;
      rej_r <= 1'b0;
    end else begin
      // Page select frozen while protect access is on or an erase walks it
      if (wr_page && !prot_sel && !erasing) begin
        page_r <= bus_wdata; // RQ10
      end
      // Protection can only be added; reset is the only way to drop it
      if (wr_page && prot_sel) begin
        prot_r <= prot_r | bus_wdata; // RQ2 RQ10
      end
      if (wr_cfg && !busy) begin
        size_r <= bus_wdata[fcps_pkg::FCPS_CFG_SIZE_BIT]; // RQ3
      end
      rej_r <= rej_nxt;
    end
  end

  // Read data register, zero when nothing is read
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rd_mux; // RQ5
    end
  end

  // Array port: one byte per clock, erase bytes first, else an accepted program
  always_ff @(posedge clk) begin
    if (!rstn) begin
      fl_we_r <= 1'b0;
      fl_addr_r <= 16'h0000;
      fl_wdata_r <= 8'h00;
      fl_info_r <= 1'b0;
    end else begin
      fl_info_r <= page_r[fcps_pkg::FCPS_INFO_BIT];
      fl_we_r <= erasing || prog_ok; // RQ12
      if (erasing) begin
        fl_addr_r <= erase_addr; // RQ9
        fl_wdata_r <= fcps_pkg::FCPS_ERASED; // RQ9
      end else if (prog_ok) begin
        fl_addr_r <= req_addr; // RQ4
        fl_wdata_r <= req_data;
      end
    end
  end

  assign bus_rdata = rdata_r;
  assign fl_addr = fl_addr_r;
  assign fl_wdata = fl_wdata_r;
  assign fl_we = fl_we_r;
  assign fl_info = fl_info_r;

  // Helper for assertions: sector index of the address on the array port
  logic [2:0] fl_sect;
  assign fl_sect = size_r ? fl_addr_r[fcps_pkg::FCPS_SECT_LSB_8K +: fcps_pkg::FCPS_SECT_W]
                          : fl_addr_r[fcps_pkg::FCPS_SECT_LSB_4K +: fcps_pkg::FCPS_SECT_W];

  property p_page_len;
    @(posedge clk) disable iff (!rstn)
      $rose(st_r == fcps_pkg::FCPS_ST_PAGE) |->
        ##[511:511] (st_r == fcps_pkg::FCPS_ST_PAGE) ##1 (st_r != fcps_pkg::FCPS_ST_PAGE);
  endproperty
  a_page_len: assert property (p_page_len) else $error("page erase not 512 bytes"); // RQ1

  property p_prot_write;
    @(posedge clk) disable iff (!rstn)
      fl_we_r |-> !prot_r[fl_sect];
  endproperty
  a_prot_write: assert property (p_prot_write) else $error("write in protected sector"); // RQ2

  property p_range;
    @(posedge clk) disable iff (!rstn)
      fl_we_r |-> (size_r ? (fl_addr_r < 16'h2000) : (fl_addr_r < 16'h1000));
  endproperty
  a_range: assert property (p_range) else $error("write beyond array size"); // RQ3

  property p_dbg_prog;
    @(posedge clk) disable iff (!rstn)
      (dbg_prog_req && prog_ok) |=> fl_we_r && (fl_addr_r == $past(dbg_prog_addr))
        && (fl_wdata_r == $past(dbg_prog_data));
  endproperty
  a_dbg_prog: assert property (p_dbg_prog) else $error("debugger byte not written"); // RQ4

  property p_state_read;
    @(posedge clk) disable iff (!rstn)
      rd_ctrl |=> (bus_rdata[5:0] == $past(code));
  endproperty
  a_state_read: assert property (p_state_read) else $error("state read wrong"); // RQ5

  property p_reserved;
    @(posedge clk) disable iff (!rstn)
      $past(rd_ctrl) |-> (bus_rdata[7:6] == 2'b00);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero"); // RQ6

  property p_first_code;
    @(posedge clk) disable iff (!rstn)
      ((st_r == fcps_pkg::FCPS_ST_LOCKED) && wr_ctrl && (bus_wdata == fcps_pkg::FCPS_CMD_UNLOCK1))
        |=> (code == 6'h01);
  endproperty
  a_first_code: assert property (p_first_code) else $error("first unlock code wrong"); // RQ7

  property p_prot_code;
    @(posedge clk) disable iff (!rstn)
      ((st_r == fcps_pkg::FCPS_ST_LOCKED) && wr_ctrl && (bus_wdata == fcps_pkg::FCPS_CMD_SECT_PROT))
        |=> (code == 6'h04);
  endproperty
  a_prot_code: assert property (p_prot_code) else $error("protect select code wrong"); // RQ7

  property p_kind;
    @(posedge clk) disable iff (!rstn)
      busy |-> ((st_r == fcps_pkg::FCPS_ST_PROG) && (code[5:3] == 3'b001))
        || ((st_r == fcps_pkg::FCPS_ST_PAGE) && (code[5:3] == 3'b010))
        || ((st_r == fcps_pkg::FCPS_ST_MASS) && (code[5:3] == 3'b100));
  endproperty
  a_kind: assert property (p_kind) else $error("operation kind code wrong"); // RQ8

  property p_erase_fill;
    @(posedge clk) disable iff (!rstn)
      ($past(st_r) == fcps_pkg::FCPS_ST_PAGE) |-> fl_we_r && (fl_wdata_r == 8'hFF)
        && (fl_addr_r[15:9] == $past(page_r[6:0]));
  endproperty
  a_erase_fill: assert property (p_erase_fill) else $error("page erase byte wrong"); // RQ9

  property p_page_hidden;
    @(posedge clk) disable iff (!rstn)
      (prot_sel && wr_page) |=> $stable(page_r);
  endproperty
  a_page_hidden: assert property (p_page_hidden) else $error("page select changed"); // RQ10

  property p_bad_seq;
    @(posedge clk) disable iff (!rstn)
      ((st_r == fcps_pkg::FCPS_ST_FIRST) && wr_ctrl && (bus_wdata != fcps_pkg::FCPS_CMD_UNLOCK2))
        |=> (st_r == fcps_pkg::FCPS_ST_LOCKED) ##1 !fl_we_r;
  endproperty
  a_bad_seq: assert property (p_bad_seq) else $error("bad unlock did not relock"); // RQ11

  property p_locked_quiet;
    @(posedge clk) disable iff (!rstn)
      ((st_r == fcps_pkg::FCPS_ST_LOCKED) && ($past(st_r) == fcps_pkg::FCPS_ST_LOCKED)) |-> !fl_we_r;
  endproperty
  a_locked_quiet: assert property (p_locked_quiet) else $error("array written while locked"); // RQ12

endmodule

// >>> fcps_flash_model.sv
/*
  Behavioural model of the flash array that sits behind the sequencer:
  an 8 KB main array and a small info area, one byte written per clock.
  Assumes the sequencer drives fl_addr, fl_wdata, fl_info and fl_we from
  registers on the rising edge of clk.
*/
module fcps_flash_model (
  input wire logic clk,
  input wire logic [15:0] fl_addr,
  input wire logic [7:0] fl_wdata,
  input wire logic fl_we,
  input wire logic fl_info,
  input wire logic [15:0] peek_addr,
  output logic [7:0] peek_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] main_mem [0:8191]; // Main array, largest size
  logic [7:0] info_mem [0:127]; // Info area, kept apart from the main array

  // Blank is 00 here, not FF, so that an erase visibly changes bytes
  initial begin
    for (int i = 0; i < 8192; i++) begin
      main_mem[i] = 8'h00;
    end
  end

  // One byte per strobe; the info flag steers it to the info area
  always @(posedge clk) begin
    if (fl_we && fl_info) begin
      info_mem[fl_addr[6:0]] <= fl_wdata;
    end else if (fl_we) begin
      main_mem[fl_addr[12:0]] <= fl_wdata;
    end
  end

  // Back door for the bench; no timing of its own
  assign peek_data = main_mem[peek_addr[12:0]];
endmodule

// >>> fcps_flash_ctrl_tb_top.sv
/*
  Self-checking bench for the flash sequencer: register reads and writes,
  unlock sequences, sector protection, byte programming and erases.
  Assumes the sequencer and the array model of this folder, one clock.
*/
module fcps_flash_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] bus_addr = 12'h000;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_rdata;
  logic cpu_prog_req = 1'b0;
  logic [15:0] cpu_prog_addr = 16'h0000;
  logic [7:0] cpu_prog_data = 8'h00;
  logic dbg_prog_req = 1'b0;
  logic [15:0] dbg_prog_addr = 16'h0000;
  logic [7:0] dbg_prog_data = 8'h00;
  logic prog_ready, fl_we, fl_info, busy;
  logic [15:0] fl_addr;
  logic [7:0] fl_wdata, peek_data;
  logic [15:0] peek_addr = 16'h0000; // Back-door address into the array
  int err_count = 0;
  int checks_done = 0;

  // 20 MHz clock
  initial begin
    forever #25 clk = ~clk;
  end

  fcps_flash_ctrl u_dut (.clk(clk), .rstn(rstn), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .cpu_prog_req(cpu_prog_req), .cpu_prog_addr(cpu_prog_addr),
    .cpu_prog_data(cpu_prog_data), .dbg_prog_req(dbg_prog_req),
    .dbg_prog_addr(dbg_prog_addr), .dbg_prog_data(dbg_prog_data),
    .prog_ready(prog_ready), .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_we(fl_we),
    .fl_info(fl_info), .busy(busy));

  fcps_flash_model u_array (.clk(clk), .fl_addr(fl_addr), .fl_wdata(fl_wdata),
    .fl_we(fl_we), .fl_info(fl_info), .peek_addr(peek_addr), .peek_data(peek_data));

  // Verdict in one place only
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Synchronous reset, held for 12 edges
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 check(bus_rdata, exp);
  endtask

  // Requests last one cycle, so an accepted one is never taken twice
  task automatic prog(input bit dbg, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    if (dbg) begin
      dbg_prog_req <= 1'b1;
      dbg_prog_addr <= a;
      dbg_prog_data <= d;
    end else begin
      cpu_prog_req <= 1'b1;
      cpu_prog_addr <= a;
      cpu_prog_data <= d;
    end
    @(posedge clk);
    dbg_prog_req <= 1'b0;
    cpu_prog_req <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic mem_chk(input logic [15:0] a, input logic [7:0] exp);
    peek_addr = a;
    #1 check(peek_data, exp);
  endtask

  task automatic unlock();
    wr(fcps_pkg::FCPS_CTRL_OFS, fcps_pkg::FCPS_CMD_UNLOCK1);
    wr(fcps_pkg::FCPS_CTRL_OFS, fcps_pkg::FCPS_CMD_UNLOCK2);
  endtask

  // Bounded wait for an erase walk to finish; running out ends the run
  task automatic wait_idle(input int limit);
    int i;
    for (i = 0; i < limit; i++) begin
      @(negedge clk);
      if (busy === 1'b0) break;
    end
    if (i == limit) begin
      err_count++;
      $display("mismatch at %0t got %h expected %h", $time, 1'b1, 1'b0);
      conclude();
    end
    // The last erase byte reaches the array one clock after busy drops
    repeat (2) @(posedge clk);
  endtask

  initial begin
    do_reset();
    rd(fcps_pkg::FCPS_CTRL_OFS, 8'h00);
    check({7'h00, prog_ready}, 8'h00);
    rd(fcps_pkg::FCPS_PAGE_OFS, fcps_pkg::FCPS_PAGE_RST);
    wr(12'hFFB, 8'hFF);
    rd(12'hFFB, 8'h00);
    rd(fcps_pkg::FCPS_CFG_OFS, 8'h00);
    $display("test reset values done");
    // Locked: a program request is refused and flagged
    prog(1'b0, 16'h0100, 8'hA5);
    mem_chk(16'h0100, 8'h00);
    rd(fcps_pkg::FCPS_CFG_OFS, 8'h02);
    wr(fcps_pkg::FCPS_CFG_OFS, 8'h02);
    rd(fcps_pkg::FCPS_CFG_OFS, 8'h00);
    // Unlock progress, wrong command and stray write both relock
    wr(fcps_pkg::FCPS_CTRL_OFS, fcps_pkg::FCPS_CMD_UNLOCK1);
    rd(fcps_pkg::FCPS_CTRL_OFS, 8'h01);
    wr(fcps_pkg::FCPS_CTRL_OFS, 8'h11);
    rd(fcps_pkg::FCPS_CTRL_OFS, 8'h00);
    wr(fcps_pkg::FCPS_CTRL_OFS, fcps_pkg::FCPS_CMD_UNLOCK1);
    wr(fcps_pkg::FCPS_PAGE_OFS, 8'h03);
    rd(fcps_pkg::FCPS_CTRL_OFS, 8'h00);
    unlock();
    rd(fcps_pkg::FCPS_CTRL_OFS, {2'b00, fcps_pkg::FCPS_CODE_UNLOCKED});
    check({7'h00, prog_ready}, 8'h01);
    $display("test unlock done");
    // Both requesters, then a tie that the debugger wins
    prog(1'b1, 16'h0040, 8'h3C);
    prog(1'b0, 16'h0041, 8'hC3);
    @(posedge clk);
    cpu_prog_req <= 1'b1;
    cpu_prog_addr <= 16'h0010;
    cpu_prog_data <= 8'h11;
    dbg_prog_req <= 1'b1;
    dbg_prog_addr <= 16'h0020;
    dbg_prog_data <= 8'h22;
    @(posedge clk);
    cpu_prog_req <= 1'b0;
    dbg_prog_req <= 1'b0;
    repeat (2) @(posedge clk);
    mem_chk(16'h0040, 8'h3C);
    mem_chk(16'h0041, 8'hC3);
    mem_chk(16'h0020, 8'h22);
    mem_chk(16'h0010, 8'h00);
    $display("test programming done");
    // Protect mode hides page select; mask bits only accumulate
    wr(fcps_pkg::FCPS_CTRL_OFS, 8'h00);
    wr(fcps_pkg::FCPS_PAGE_OFS, 8'h03);
    wr(fcps_pkg::FCPS_CTRL_OFS, fcps_pkg::FCPS_CMD_SECT_PROT);
    rd(fcps_pkg::FCPS_CTRL_OFS, {2'b00, fcps_pkg::FCPS_CODE_PROT});
    rd(fcps_pkg::FCPS_PAGE_OFS, fcps_pkg::FCPS_PROT_RST);
    wr(fcps_pkg::FCPS_PAGE_OFS, 8'h04);
    wr(fcps_pkg::FCPS_PAGE_OFS, 8'h01);
    rd(fcps_pkg::FCPS_PAGE_OFS, 8'h05);
    wr(fcps_pkg::FCPS_CTRL_OFS, 8'h00);
    rd(fcps_pkg::FCPS_PAGE_OFS, 8'h03);
    // Sectors 0 and 2 protected, 512-byte sectors
    unlock();
    prog(1'b0, 16'h05FF, 8'h77);
    prog(1'b0, 16'h1000, 8'h77);
    prog(1'b0, 16'h0200, 8'h66);
    mem_chk(16'h05FF, 8'h00);
    mem_chk(16'h0200, 8'h66);
    rd(fcps_pkg::FCPS_CFG_OFS, 8'h02);
    // Same mask with 1024-byte sectors
    wr(fcps_pkg::FCPS_CFG_OFS, 8'h03);
    prog(1'b0, 16'h0300, 8'h55);
    prog(1'b0, 16'h0A00, 8'h55);
    prog(1'b1, 16'h0C00, 8'h44);
    prog(1'b1, 16'h1000, 8'h5A);
    mem_chk(16'h0300, 8'h00);
    mem_chk(16'h0A00, 8'h00);
    mem_chk(16'h0C00, 8'h44);
    mem_chk(16'h1000, 8'h5A);
    rd(fcps_pkg::FCPS_CFG_OFS, 8'h03);
    wr(fcps_pkg::FCPS_CFG_OFS, 8'h02);
    $display("test protection done");
    // Page 3 erase clears exactly 0600..07FF; relock first, since unlocked
    // state treats an unlock command as a wrong command
    wr(fcps_pkg::FCPS_CTRL_OFS, 8'h00);
    unlock();
    wr(fcps_pkg::FCPS_CTRL_OFS, fcps_pkg::FCPS_CMD_PAGE_ERASE);
    rd(fcps_pkg::FCPS_CTRL_OFS, {2'b00, fcps_pkg::FCPS_CODE_PAGE});
    check({7'h00, busy}, 8'h01);
    wait_idle(600);
    mem_chk(16'h05FF, 8'h00);
    mem_chk(16'h0600, fcps_pkg::FCPS_ERASED);
    mem_chk(16'h07FF, fcps_pkg::FCPS_ERASED);
    mem_chk(16'h0800, 8'h00);
    rd(fcps_pkg::FCPS_CTRL_OFS, 8'h00);
    // Erases touching protection are refused
    wr(fcps_pkg::FCPS_PAGE_OFS, 8'h00);
    unlock();
    wr(fcps_pkg::FCPS_CTRL_OFS, fcps_pkg::FCPS_CMD_PAGE_ERASE);
    rd(fcps_pkg::FCPS_CTRL_OFS, 8'h00);
    unlock();
    wr(fcps_pkg::FCPS_CTRL_OFS, fcps_pkg::FCPS_CMD_MASS_ERASE);
    rd(fcps_pkg::FCPS_CTRL_OFS, 8'h00);
    rd(fcps_pkg::FCPS_CFG_OFS, 8'h02);
    mem_chk(16'h0040, 8'h3C);
    $display("test erase done");
    // Second reset drops protection; mass erase covers 4 KB only
    do_reset();
    unlock();
    wr(fcps_pkg::FCPS_CTRL_OFS, fcps_pkg::FCPS_CMD_MASS_ERASE);
    rd(fcps_pkg::FCPS_CTRL_OFS, {2'b00, fcps_pkg::FCPS_CODE_MASS});
    wait_idle(4200);
    mem_chk(16'h0000, fcps_pkg::FCPS_ERASED);
    mem_chk(16'h0FFF, fcps_pkg::FCPS_ERASED);
    mem_chk(16'h1000, 8'h5A);
    rd(fcps_pkg::FCPS_CTRL_OFS, 8'h00);
    // Mass erase of the 8 KB array reaches the top byte
    wr(fcps_pkg::FCPS_CFG_OFS, 8'h01);
    unlock();
    wr(fcps_pkg::FCPS_CTRL_OFS, fcps_pkg::FCPS_CMD_MASS_ERASE);
    wait_idle(8400);
    mem_chk(16'h1000, fcps_pkg::FCPS_ERASED);
    mem_chk(16'h1FFF, fcps_pkg::FCPS_ERASED);
    // Info area enable reaches the array one clock after the write
    wr(fcps_pkg::FCPS_PAGE_OFS, 8'h80);
    @(posedge clk);
    #1 check({7'h00, fl_info}, 8'h01);
    $display("test mass erase done");
    conclude();
  end
endmodule
